//--- rtl/mog_top.sv
// top: synchronised fault gating, registers and registered driver outputs
`timescale 1ns/10ps
module mog_top
    import mog_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [AW-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    output logic irq,
    input wire logic resetInN,
    input wire logic thermalShutdown,
    input wire mog_pkg::mog_bridge_in_t [NUM_BRIDGE-1:0] bridgeIn,
    input wire logic [NUM_AUX-1:0] overcurrentFlagAux,
    input wire logic [NUM_PHASE-1:0][1:0] phaseBits,
    input wire logic [NUM_PHASE-1:0] stepperPwmIn,
    input wire logic [NUM_PHASE-1:0] overcurrentFlagStep,
    output mog_pkg::mog_hb_pins_t [NUM_BRIDGE-1:0] halfBridgeOutA,
    output mog_pkg::mog_hb_pins_t [NUM_BRIDGE-1:0] halfBridgeOutB,
    output mog_pkg::mog_sw_t [NUM_AUX-1:0] lowSideSwitchOut,
    output mog_pkg::mog_sw_t [NUM_AUX-1:0] highSideSwitchOut,
    output logic [NUM_PHASE-1:0][1:0] coilOut
);
    // two-flop synchronisers for all pin inputs
    localparam int SW = 2 + NUM_BRIDGE * 5 + NUM_AUX + NUM_PHASE * 4;
    logic [SW-1:0] syncRaw;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic [SW-1:0] sync1_next;
    logic [SW-1:0] sync2_next;
    assign syncRaw = {resetInN, thermalShutdown, bridgeIn, overcurrentFlagAux,
                      phaseBits, stepperPwmIn, overcurrentFlagStep};

    logic sRstIn;
    logic sTsd;
    mog_bridge_in_t [NUM_BRIDGE-1:0] sBridge;
    logic [NUM_AUX-1:0] sAuxLim;
    logic [NUM_PHASE-1:0][1:0] sPhase;
    logic [NUM_PHASE-1:0] sSpwm;
    logic [NUM_PHASE-1:0] sStepLim;
    assign {sRstIn, sTsd, sBridge, sAuxLim, sPhase, sSpwm, sStepLim} = sync2_reg;

    always_comb begin
        sync1_next = syncRaw;
        sync2_next = sync1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // register file
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [EV_W-1:0] status_reg;
    logic [EV_W-1:0] status_next;
    logic [EV_W-1:0] mask_reg;
    logic [EV_W-1:0] mask_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] evLevel_reg;
    logic [EV_W-1:0] evLevel_next;
    logic [15:0] outsView;

    logic driveSel;
    logic [NUM_AUX-1:0] auxCmd;
    assign driveSel = ctrl_reg[CTRL_SEL_BIT];
    assign auxCmd = {ctrl_reg[CMD_SECOND_BIT], ctrl_reg[CMD_FIRST_BIT]};

    always_comb begin
        evLevel_next[EV_TSD] = sTsd;
        evLevel_next[EV_BRIDGE_LIM] = |{sBridge[0].limTop, sBridge[0].limBottom,
                                        sBridge[1].limTop, sBridge[1].limBottom};
        evLevel_next[EV_AUX_LIM] = |sAuxLim;
        evLevel_next[EV_STEP_LIM] = |sStepLim;
        events = evLevel_next & ~evLevel_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        if (regWr && regAddr == ADDR_CTRL) begin
            ctrl_next = regWdata;
        end
        if (regWr && regAddr == ADDR_MASK) begin
            mask_next = regWdata[EV_W-1:0];
        end
        if (regWr && regAddr == ADDR_STATUS) begin
            status_next = status_reg & ~regWdata[EV_W-1:0];
        end
        status_next = status_next | events;
        irq_next = |(status_next & mask_next);
        rdata_next = 16'h0000;
        if (regRd) begin
            case (regAddr)
                ADDR_CTRL: rdata_next = ctrl_reg;
                ADDR_STATUS: rdata_next = {12'h000, status_reg};
                ADDR_MASK: rdata_next = {12'h000, mask_reg};
                ADDR_OUTS: rdata_next = outsView;
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= EV_ZERO;
            status_reg <= EV_ZERO;
            evLevel_reg <= EV_ZERO;
            irq_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            evLevel_reg <= evLevel_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end
    assign regRdata = rdata_reg;
    assign irq = irq_reg;

    // dc bridges
    mog_hb_t [NUM_BRIDGE-1:0] hbA;
    mog_hb_t [NUM_BRIDGE-1:0] hbB;
    mog_hb_pins_t [NUM_BRIDGE-1:0] hbA_reg;
    mog_hb_pins_t [NUM_BRIDGE-1:0] hbB_reg;
    mog_hb_pins_t [NUM_BRIDGE-1:0] hbA_next;
    mog_hb_pins_t [NUM_BRIDGE-1:0] hbB_next;

    for (genvar i = 0; i < NUM_BRIDGE; i++) begin : g_bridge
        mog_bridge_decode u_dec (
            .in(sBridge[i]),
            .thermal_shutdown(sTsd),
            .rstIn(sRstIn),
            .outA(hbA[i]),
            .outB(hbB[i])
        );
        // three-state pin mapping
        always_comb begin
            hbA_next[i].hiOn = (hbA[i] == HB_HIGH);
            hbA_next[i].hiOe = (hbA[i] != HB_OFF);
            hbA_next[i].loOn = (hbA[i] == HB_LOW);
            hbB_next[i].hiOn = (hbB[i] == HB_HIGH);
            hbB_next[i].hiOe = (hbB[i] != HB_OFF);
            hbB_next[i].loOn = (hbB[i] == HB_LOW);
        end
    end

    // aux switches
    mog_sw_t [NUM_AUX-1:0] ls_reg;
    mog_sw_t [NUM_AUX-1:0] ls_next;
    mog_sw_t [NUM_AUX-1:0] hs_reg;
    mog_sw_t [NUM_AUX-1:0] hs_next;
    for (genvar j = 0; j < NUM_AUX; j++) begin : g_aux
        always_comb begin
            ls_next[j] = '0;
            hs_next[j] = '0;
            if (!sTsd && sRstIn && auxCmd[j]) begin
                if (driveSel) begin
                    ls_next[j].on = 1'b1;
                    ls_next[j].limited = sAuxLim[j];
                end else begin
                    hs_next[j].on = 1'b1;
                    hs_next[j].limited = sAuxLim[j];
                end
            end
        end
    end

    // stepper phases
    logic [NUM_PHASE-1:0][1:0] coil_reg;
    logic [NUM_PHASE-1:0][1:0] coil_next;
    for (genvar k = 0; k < NUM_PHASE; k++) begin : g_step
        always_comb begin
            coil_next[k] = 2'b00;
            if (sTsd || !sRstIn) begin
                coil_next[k] = 2'b00;
            end else if (sStepLim[k]) begin
                coil_next[k] = 2'b00;
            end else if (!driveSel) begin
                case (sPhase[k])
                    2'b01: coil_next[k] = sSpwm[k] ? 2'b10 : 2'b01;
                    2'b10: coil_next[k] = sSpwm[k] ? 2'b01 : 2'b10;
                    default: coil_next[k] = 2'b00;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int b = 0; b < NUM_BRIDGE; b++) begin
                hbA_reg[b] <= '0;
                hbB_reg[b] <= '0;
            end
            ls_reg <= '0;
            hs_reg <= '0;
            coil_reg <= '0;
        end else begin
            hbA_reg <= hbA_next;
            hbB_reg <= hbB_next;
            ls_reg <= ls_next;
            hs_reg <= hs_next;
            coil_reg <= coil_next;
        end
    end

    assign halfBridgeOutA = hbA_reg;
    assign halfBridgeOutB = hbB_reg;
    assign lowSideSwitchOut = ls_reg;
    assign highSideSwitchOut = hs_reg;
    assign coilOut = coil_reg;
    assign outsView = {hbA_reg[0].hiOn, hbA_reg[0].hiOe, hbB_reg[0].hiOn, hbB_reg[0].hiOe,
                       hbA_reg[1].hiOn, hbA_reg[1].hiOe, hbB_reg[1].hiOn, hbB_reg[1].hiOe,
                       ls_reg[1].on, ls_reg[0].on, hs_reg[1].on, hs_reg[0].on, coil_reg};
endmodule : mog_top

//--- rtl/mog_pkg.sv
// package: constants, types and register map of the motor output gating block
//
// Summary of operation
// - bridge output is low-on, high-on or both-off (high impedance).
// - thermal shutdown floats both half-bridge outputs regardless of any input.
// - bottom-only limit drives both high; top limit drives both low.
// - reset low gives low/low; otherwise direction and pwm truth table.
// - low-side switches usable only when drive-type select is 1 (dc).
// - low-side switch off in shutdown or reset; follows command; limited on trip.
// - high-side switches usable only when drive-type select is 0.
// - high-side switch off in shutdown or reset; follows command; limited on trip.
// - stepper coils off in shutdown or reset; limited or off on trip.
// - phase 00/11 off; 01 and 10 pick a coil by pwm level.
// - pwm toggling switches on the counterphase coil for synchronous rectification.
// - limit sensing may drop while disabled; oscillation is tolerated.
// - dc mode enables low-side switches; stepper mode enables high-side switches.
// - configuration bits, drive-type select included, reset to 0.
package mog_pkg;
    localparam int NUM_BRIDGE = 2;
    localparam int NUM_AUX = 2;
    localparam int NUM_PHASE = 2;
    localparam int AW = 4;
    localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
    localparam logic [AW-1:0] ADDR_STATUS = 4'h1;
    localparam logic [AW-1:0] ADDR_MASK = 4'h2;
    localparam logic [AW-1:0] ADDR_OUTS = 4'h3;
    localparam int CTRL_SEL_BIT = 4;
    localparam int CMD_FIRST_BIT = 14;
    localparam int CMD_SECOND_BIT = 15;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int EV_W = 4;
    localparam int EV_TSD = 0;
    localparam int EV_BRIDGE_LIM = 1;
    localparam int EV_AUX_LIM = 2;
    localparam int EV_STEP_LIM = 3;
    localparam logic [EV_W-1:0] EV_ZERO = 4'h0;

    // drive state of one half-bridge
    typedef enum logic [2:0] {
        HB_OFF = 3'b001,
        HB_LOW = 3'b010,
        HB_HIGH = 3'b100
    } mog_hb_t;

    typedef struct packed {
        logic dirA;
        logic dirB;
        logic pwm;
        logic limTop;
        logic limBottom;
    } mog_bridge_in_t;

    typedef struct packed {
        logic hiOn;
        logic hiOe;
        logic loOn;
    } mog_hb_pins_t;

    // aux drive: on and current-limit-active
    typedef struct packed {
        logic on;
        logic limited;
    } mog_sw_t;
endpackage : mog_pkg

//--- rtl/mog_bridge_decode.sv
// half-bridge decode for one dc channel
`timescale 1ns/10ps
module mog_bridge_decode
    import mog_pkg::*;
(
    input wire mog_pkg::mog_bridge_in_t in,
    input wire logic thermal_shutdown,
    input wire logic rstIn,
    output mog_pkg::mog_hb_t outA,
    output mog_pkg::mog_hb_t outB
);
    always_comb begin
        outA = HB_LOW;
        outB = HB_LOW;
        if (thermal_shutdown) begin
            outA = HB_OFF;
            outB = HB_OFF;
        end else if (in.limTop) begin
            outA = HB_LOW;
            outB = HB_LOW;
        end else if (in.limBottom) begin
            outA = HB_HIGH;
            outB = HB_HIGH;
        end else if (!rstIn) begin
            outA = HB_LOW;
            outB = HB_LOW;
        end else begin
            case ({in.dirA, in.dirB})
                2'b00: begin
                    outA = HB_LOW;
                    outB = HB_LOW;
                end
                2'b01: begin
                    outA = in.pwm ? HB_LOW : HB_HIGH;
                    outB = HB_HIGH;
                end
                2'b10: begin
                    outA = HB_HIGH;
                    outB = in.pwm ? HB_LOW : HB_HIGH;
                end
                default: begin
                    outA = HB_HIGH;
                    outB = HB_HIGH;
                end
            endcase
        end
    end
endmodule : mog_bridge_decode

//--- testbench/mog_monitor.sv
// checker: gating relations watched at the top ports
`timescale 1ns/10ps
module mog_monitor
    import mog_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic resetInN,
    input wire logic thermalShutdown,
    input wire mog_pkg::mog_bridge_in_t [NUM_BRIDGE-1:0] bridgeIn,
    input wire logic [NUM_PHASE-1:0][1:0] phaseBits,
    input wire logic [NUM_PHASE-1:0] stepperPwmIn,
    input wire logic [NUM_PHASE-1:0] overcurrentFlagStep,
    input wire mog_pkg::mog_hb_pins_t [NUM_BRIDGE-1:0] halfBridgeOutA,
    input wire mog_pkg::mog_hb_pins_t [NUM_BRIDGE-1:0] halfBridgeOutB,
    input wire mog_pkg::mog_sw_t [NUM_AUX-1:0] lowSideSwitchOut,
    input wire mog_pkg::mog_sw_t [NUM_AUX-1:0] highSideSwitchOut,
    input wire logic [NUM_PHASE-1:0][1:0] coilOut
);
    logic [2:0] upReg;
    logic [2:0] upNext;
    always_comb upNext = (upReg == 3'h4) ? upReg : upReg + 3'h1;
    always_ff @(posedge clk) upReg <= rst ? 3'h0 : upNext;
    // level code: z 2, high 1, low 0
    function automatic logic [1:0] lv(mog_hb_pins_t p);
        if (!p.hiOe && !p.loOn) return 2'b10;
        if (p.hiOe && p.hiOn && !p.loOn) return 2'b01;
        return (p.loOn && !p.hiOn) ? 2'b00 : 2'b11;
    endfunction : lv
    function automatic logic [3:0] dcExp(mog_bridge_in_t b);
        if (b.dirA == b.dirB) return {1'b0, b.dirA, 1'b0, b.dirA};
        return b.pwm ? {1'b0, b.dirA, 1'b0, b.dirB} : 4'b0101;
    endfunction : dcExp
    function automatic logic [1:0] stExp(logic [1:0] ph, logic pwm);
        if (ph[1] == ph[0]) return 2'b00;
        return (ph[0] ^ pwm) ? 2'b01 : 2'b10;
    endfunction : stExp
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence sCool;
        upReg == 3'h4 && !$past(thermalShutdown, 3);
    endsequence
    sequence sRun;
        sCool ##0 $past(resetInN, 3);
    endsequence
    for (genvar i = 0; i < NUM_BRIDGE; i++) begin : g_ch
        wire [3:0] ab = {lv(halfBridgeOutA[i]), lv(halfBridgeOutB[i])};
        tsd_float_a: assert property (upReg == 3'h4 && $past(thermalShutdown, 3) |-> ab == 4'hA)
            else $error("bridge driven during shutdown");
        top_limit_a: assert property (sCool ##0 $past(bridgeIn[i].limTop, 3) |-> ab == 4'h0)
            else $error("top limit did not force low");
        bottom_limit_a: assert property (sCool ##0 $past(bridgeIn[i][1:0], 3) == 2'b01 |-> ab == 4'h5)
            else $error("bottom limit did not force high");
        reset_low_a: assert property (sCool ##0 $past(bridgeIn[i][1:0], 3) == 2'b00 && !$past(resetInN, 3)
            |-> ab == 4'h0) else $error("reset did not force low");
        dc_table_a: assert property (sRun ##0 $past(bridgeIn[i][1:0], 3) == 2'b00
            |-> ab == dcExp($past(bridgeIn[i], 3))) else $error("bridge decode wrong");
        aux_gate_a: assert property (upReg == 3'h4 && (lowSideSwitchOut[i].on || highSideSwitchOut[i].on)
            |-> sRun) else $error("aux switch on while gated");
        aux_excl_a: assert property (!(lowSideSwitchOut[i].on && highSideSwitchOut[i].on))
            else $error("low and high aux both on");
        coil_off_a: assert property (upReg == 3'h4 && ($past(thermalShutdown, 3) || !$past(resetInN, 3)
            || $past(overcurrentFlagStep[i], 3)) |-> coilOut[i] == 2'b00) else $error("coil on while gated");
        coil_decode_a: assert property (upReg == 3'h4 && coilOut[i] != 2'b00
            |-> coilOut[i] == stExp($past(phaseBits[i], 3), $past(stepperPwmIn[i], 3))) else $error("coil decode wrong");
    end
endmodule : mog_monitor
bind mog_top mog_monitor mog_monitor_i (.clk, .rst, .resetInN, .thermalShutdown, .bridgeIn, .phaseBits, .stepperPwmIn,
    .overcurrentFlagStep, .halfBridgeOutA, .halfBridgeOutB, .lowSideSwitchOut, .highSideSwitchOut, .coilOut);

//--- testbench/mog_winding_model.sv
// partner: winding model raising aux current-limit flags on command
`timescale 1ns/10ps
module mog_winding_model
    import mog_pkg::*;
(
    input wire logic [NUM_AUX-1:0] tripAux,
    input wire mog_pkg::mog_sw_t [NUM_AUX-1:0] lowSideSwitchOut,
    input wire mog_pkg::mog_sw_t [NUM_AUX-1:0] highSideSwitchOut,
    output logic [NUM_AUX-1:0] overcurrentFlagAux
);
    // current, and so a trip, only while a switch conducts
    always_comb begin
        for (int i = 0; i < NUM_AUX; i++) begin
            overcurrentFlagAux[i] = tripAux[i] && (lowSideSwitchOut[i].on || highSideSwitchOut[i].on);
        end
    end
endmodule : mog_winding_model

//--- testbench/tb_top.sv
// testbench: register access and output gating scenarios
`timescale 1ns/10ps
module tb_top;
    import mog_pkg::*;
    logic clk, rst, regWr, regRd, irq, resetInN, thermalShutdown;
    logic [AW-1:0] regAddr;
    logic [15:0] regWdata, regRdata;
    mog_bridge_in_t [NUM_BRIDGE-1:0] bridgeIn;
    logic [NUM_AUX-1:0] overcurrentFlagAux, tripAux;
    logic [NUM_PHASE-1:0][1:0] phaseBits, coilOut;
    logic [NUM_PHASE-1:0] stepperPwmIn, overcurrentFlagStep;
    mog_hb_pins_t [NUM_BRIDGE-1:0] halfBridgeOutA, halfBridgeOutB;
    mog_sw_t [NUM_AUX-1:0] lowSideSwitchOut, highSideSwitchOut;
    int errCount = 0, cmpCount = 0, cycles = 0;
    // {reset pin, shutdown, bridge input, expected levels a and b}
    logic [10:0] cs [15] = '{11'h400, 11'h440, 11'h485, 11'h4C1, 11'h505, 11'h544, 11'h585, 11'h5C5,
        11'h4D5, 11'h4E0, 11'h4F0, 11'h0D5, 11'h0C0, 11'h6DA, 11'h38A};
    localparam logic [15:0] STEP_TBL = 16'h0690;
    mog_top mog_top_i (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq, .resetInN,
        .thermalShutdown, .bridgeIn, .overcurrentFlagAux, .phaseBits, .stepperPwmIn, .overcurrentFlagStep,
        .halfBridgeOutA, .halfBridgeOutB, .lowSideSwitchOut, .highSideSwitchOut, .coilOut);
    mog_winding_model mog_winding_model_i (.tripAux, .lowSideSwitchOut, .highSideSwitchOut, .overcurrentFlagAux);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(logic [15:0] got, logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(logic [AW-1:0] a, logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(logic [AW-1:0] a, logic [15:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check(regRdata, exp);
    endtask : rd
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    function automatic logic [1:0] lvl(mog_hb_pins_t p);
        if (p.hiOe === 1'b0 && p.loOn === 1'b0) return 2'b10;
        if (p.hiOe === 1'b1 && p.hiOn === 1'b1 && p.loOn === 1'b0) return 2'b01;
        return (p.loOn === 1'b1 && p.hiOn === 1'b0) ? 2'b00 : 2'b11;
    endfunction : lvl
    task automatic chkAux(logic [7:0] e);
        check({8'h00, lowSideSwitchOut[0].on, lowSideSwitchOut[1].on, highSideSwitchOut[0].on, highSideSwitchOut[1].on,
            lowSideSwitchOut[0].limited, lowSideSwitchOut[1].limited, highSideSwitchOut[0].limited,
            highSideSwitchOut[1].limited}, {8'h00, e});
    endtask : chkAux
    task automatic endOfTest;
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : endOfTest
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            endOfTest;
        end
    end
    initial begin
        {rst, regWr, regRd, regAddr, regWdata, resetInN, thermalShutdown} = {3'b100, 20'h0, 2'b00};
        {bridgeIn, tripAux, phaseBits, stepperPwmIn, overcurrentFlagStep} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(4'hF, 16'h0000);
        for (int k = 0; k < 15; k++) begin
            @(posedge clk);
            {resetInN, thermalShutdown} <= cs[k][10:9];
            bridgeIn <= {2{cs[k][8:4]}};
            settle;
            check({lvl(halfBridgeOutA[0]), lvl(halfBridgeOutB[0]), lvl(halfBridgeOutA[1]), lvl(halfBridgeOutB[1]),
                8'h00}, {cs[k][3:0], cs[k][3:0], 8'h00});
        end
        rd(ADDR_STATUS, 16'h0003);
        check({15'h0, irq}, 16'h0000);
        wr(ADDR_MASK, 16'h0001);
        settle;
        check({15'h0, irq}, 16'h0001);
        rd(ADDR_MASK, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        rd(ADDR_STATUS, 16'h0002);
        check({15'h0, irq}, 16'h0000);
        @(posedge clk);
        {resetInN, thermalShutdown, bridgeIn} <= {2'b10, 10'h0};
        wr(ADDR_CTRL, 16'h4010);
        settle;
        chkAux(8'h80);
        wr(ADDR_CTRL, 16'h8000);
        settle;
        chkAux(8'h10);
        @(posedge clk);
        tripAux <= 2'b10;
        settle;
        chkAux(8'h11);
        @(posedge clk);
        thermalShutdown <= 1'b1;
        settle;
        chkAux(8'h00);
        @(posedge clk);
        {resetInN, thermalShutdown, tripAux} <= 4'b0001;
        wr(ADDR_CTRL, 16'hC010);
        settle;
        chkAux(8'h00);
        @(posedge clk);
        resetInN <= 1'b1;
        settle;
        settle;
        chkAux(8'hC8);
        rd(ADDR_OUTS, 16'h55C0);
        wr(ADDR_CTRL, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            phaseBits <= {2{k[2:1]}};
            stepperPwmIn <= {2{k[0]}};
            settle;
            check({12'h0, coilOut}, {12'h0, {2{STEP_TBL[2*k+:2]}}});
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            {resetInN, thermalShutdown, overcurrentFlagStep} <= (k == 0) ? 4'b1011 : (k == 1) ? 4'b1100 : 4'b0000;
            phaseBits <= {2{2'b01}};
            settle;
            check({12'h0, coilOut}, 16'h0000);
        end
        rd(ADDR_STATUS, 16'h000F);
        wr(ADDR_CTRL, 16'h4010);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        endOfTest;
    end
endmodule : tb_top
